// file: hw/chain_cfg_pkg.sv
// constants and field layout of the chain configuration and timer registers
// Function
// - allocated address read-only, 6 bits, upper bits zero, writes ignored
// - link rate code 00 5 kHz, 01 20 kHz, 10 40 kHz, 11 reserved
// - link speed register reachable only from the host four-wire port
// - warning and shutdown thresholds: 4-bit codes, 3.165 to 4.155 linear
// - duty code 000 25%, then 15,20,30,35,40,45,50 percent
// - slot code 00 1 s, 01 8 s, 10 16 s, 11 32 s
// - timer clock code 00 100k, 01 25k, 10 50k, 11 200 kHz
// - top timer bit picks 5 or 15 comparator settle cycles
// - link status reports allocation start write pass 0 or fail 1
package chain_cfg_pkg;
	// ******************************
	// register offsets
	// ******************************
	localparam logic [7:0] ADDR_ALLOC_TARGET = 8'h1a;
	localparam logic [7:0] ADDR_ASSIGNED = 8'h1b;
	localparam logic [7:0] ADDR_LINK_SPEED = 8'h1c;
	localparam logic [7:0] ADDR_OT_THRESH = 8'h1d;
	localparam logic [7:0] ADDR_BAL_TIMER = 8'h1e;
	localparam logic [7:0] ADDR_LINK_STATUS = 8'h19;
	// ******************************
	// field masks and positions
	// ******************************
	localparam logic [7:0] MASK_ADDR = 8'h3f;
	localparam logic [7:0] MASK_SPEED = 8'h03;
	localparam logic [7:0] MASK_FULL = 8'hff;
	localparam int POS_ALLOC_FAIL = 2;
	localparam int POS_DUTY = 0;
	localparam int POS_SLOT = 3;
	localparam int POS_TCLK = 5;
	localparam int POS_SETTLE = 7;
	localparam int POS_OT_WARN = 0;
	localparam int POS_OT_SHUT = 4;
	localparam logic [7:0] RESET_VALUE = 8'h00;
	localparam logic [1:0] SPEED_RESERVED = 2'h3;
	// ******************************
	// decoded settings
	// ******************************
	localparam logic [4:0] SETTLE_SHORT = 5'h05;
	localparam logic [4:0] SETTLE_LONG = 5'h0f;
	// threshold in millivolts: 3165 + 66 * code
	localparam logic [12:0] OT_BASE_MV = 13'h0c5d;
	localparam logic [12:0] OT_STEP_MV = 13'h0042;
endpackage

// file: hw/cfg_field_decode.sv
// decode of the timer and link speed fields into usable settings
`timescale 1ns/10ps
`default_nettype none
module cfg_field_decode
	import chain_cfg_pkg::*;
(
	input wire logic [7:0] i_timer,
	input wire logic [7:0] i_speed,
	input wire logic [7:0] i_ot,
	output logic [5:0] o_duty_pct,
	output logic [5:0] o_slot_s,
	output logic [7:0] o_tclk_khz,
	output logic [4:0] o_settle_cycles,
	output logic [5:0] o_link_khz,
	output logic o_speed_invalid,
	output logic [12:0] o_warn_mv,
	output logic [12:0] o_shut_mv
);
	wire logic [2:0] duty_code = i_timer[POS_DUTY +: 3];
	wire logic [1:0] slot_code = i_timer[POS_SLOT +: 2];
	wire logic [1:0] tclk_code = i_timer[POS_TCLK +: 2];
	wire logic [3:0] warn_code = i_ot[POS_OT_WARN +: 4];
	wire logic [3:0] shut_code = i_ot[POS_OT_SHUT +: 4];

	assign o_duty_pct = (duty_code == 3'h0) ? 6'd25 :
		(duty_code == 3'h1) ? 6'd15 :
		(duty_code == 3'h2) ? 6'd20 :
		(duty_code == 3'h3) ? 6'd30 :
		(duty_code == 3'h4) ? 6'd35 :
		(duty_code == 3'h5) ? 6'd40 :
		(duty_code == 3'h6) ? 6'd45 : 6'd50;
	assign o_slot_s = (slot_code == 2'h0) ? 6'd1 :
		(slot_code == 2'h1) ? 6'd8 :
		(slot_code == 2'h2) ? 6'd16 : 6'd32;
	assign o_tclk_khz = (tclk_code == 2'h0) ? 8'd100 :
		(tclk_code == 2'h1) ? 8'd25 :
		(tclk_code == 2'h2) ? 8'd50 : 8'd200;
	assign o_settle_cycles = i_timer[POS_SETTLE] ? SETTLE_LONG : SETTLE_SHORT;
	assign o_link_khz = (i_speed[1:0] == 2'h0) ? 6'd5 :
		(i_speed[1:0] == 2'h1) ? 6'd20 :
		(i_speed[1:0] == 2'h2) ? 6'd40 : 6'd0;
	assign o_speed_invalid = (i_speed[1:0] == SPEED_RESERVED);
	assign o_warn_mv = 13'(OT_BASE_MV + OT_STEP_MV * {9'h000, warn_code});
	assign o_shut_mv = 13'(OT_BASE_MV + OT_STEP_MV * {9'h000, shut_code});
endmodule
`default_nettype wire

// file: hw/chain_config_timer_regs.sv
// register group for chain addressing, link speed, thresholds and timer
`timescale 1ns/10ps
`default_nettype none
module chain_config_timer_regs
	import chain_cfg_pkg::*;
(
	input wire logic i_clk_sys,
	input wire logic i_rstn,
	// host four-wire port register access
	input wire logic i_host_wr,
	input wire logic i_host_rd,
	input wire logic [7:0] i_host_addr,
	input wire logic [7:0] i_host_wdata,
	output logic [7:0] o_host_rdata,
	output logic o_host_hit,
	// chained three-wire port register access
	input wire logic i_chain_wr,
	input wire logic i_chain_rd,
	input wire logic [7:0] i_chain_addr,
	input wire logic [7:0] i_chain_wdata,
	output logic [7:0] o_chain_rdata,
	output logic o_chain_hit,
	// allocation engine
	input wire logic i_alloc_done,
	input wire logic [5:0] i_alloc_addr,
	input wire logic i_alloc_start_result,
	input wire logic i_alloc_start_fail,
	// decoded settings
	output logic [5:0] o_target_addr,
	output logic [5:0] o_device_addr,
	output logic o_alloc_fail,
	output logic [5:0] o_link_khz,
	output logic o_speed_invalid,
	output logic [3:0] o_ot_warn_code,
	output logic [3:0] o_ot_shut_code,
	output logic [12:0] o_warn_mv,
	output logic [12:0] o_shut_mv,
	output logic [5:0] o_duty_pct,
	output logic [5:0] o_slot_s,
	output logic [7:0] o_tclk_khz,
	output logic [4:0] o_settle_cycles
);
	// ******************************
	// reset release
	// ******************************
	logic rst_sync1_q;
	logic rst_sync2_q;
	wire logic rstn = rst_sync2_q;

	// two-stage release of the power-on reset
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			rst_sync1_q <= 1'b0;
			rst_sync2_q <= 1'b0;
		end else begin
			rst_sync1_q <= 1'b1;
			rst_sync2_q <= rst_sync1_q;
		end
	end

	// ******************************
	// storage
	// ******************************
	logic [7:0] target_q;
	logic [7:0] assigned_q;
	logic [7:0] speed_q;
	logic [7:0] ot_q;
	logic [7:0] timer_q;
	logic fail_q;

	// write decode; host wins when both ports write together
	wire logic h_tgt = i_host_wr && (i_host_addr == ADDR_ALLOC_TARGET);
	wire logic c_tgt = i_chain_wr && (i_chain_addr == ADDR_ALLOC_TARGET);
	wire logic h_ot = i_host_wr && (i_host_addr == ADDR_OT_THRESH);
	wire logic c_ot = i_chain_wr && (i_chain_addr == ADDR_OT_THRESH);
	wire logic h_tmr = i_host_wr && (i_host_addr == ADDR_BAL_TIMER);
	wire logic c_tmr = i_chain_wr && (i_chain_addr == ADDR_BAL_TIMER);
	// link speed written only from host port
	wire logic h_spd = i_host_wr && (i_host_addr == ADDR_LINK_SPEED);

	wire logic [7:0] target_d = h_tgt ? (i_host_wdata & MASK_ADDR) :
		c_tgt ? (i_chain_wdata & MASK_ADDR) : target_q;
	// allocated address set only by the allocation engine
	wire logic [7:0] assigned_d = i_alloc_done ?
		{2'b00, i_alloc_addr} : assigned_q;
	wire logic [7:0] speed_d = h_spd ? (i_host_wdata & MASK_SPEED) : speed_q;
	wire logic [7:0] ot_d = h_ot ? i_host_wdata :
		c_ot ? i_chain_wdata : ot_q;
	wire logic [7:0] timer_d = h_tmr ? i_host_wdata :
		c_tmr ? i_chain_wdata : timer_q;
	// pass or fail of the start address write
	wire logic fail_d = i_alloc_start_result ? i_alloc_start_fail : fail_q;

	always_ff @(posedge i_clk_sys or negedge rstn) begin
		if (!rstn) begin
			target_q <= RESET_VALUE;
		end else begin
			target_q <= target_d;
		end
	end

	always_ff @(posedge i_clk_sys or negedge rstn) begin
		if (!rstn) begin
			assigned_q <= RESET_VALUE;
		end else begin
			assigned_q <= assigned_d;
		end
	end

	always_ff @(posedge i_clk_sys or negedge rstn) begin
		if (!rstn) begin
			speed_q <= RESET_VALUE;
		end else begin
			speed_q <= speed_d;
		end
	end

	always_ff @(posedge i_clk_sys or negedge rstn) begin
		if (!rstn) begin
			ot_q <= RESET_VALUE;
		end else begin
			ot_q <= ot_d;
		end
	end

	always_ff @(posedge i_clk_sys or negedge rstn) begin
		if (!rstn) begin
			timer_q <= RESET_VALUE;
		end else begin
			timer_q <= timer_d;
		end
	end

	always_ff @(posedge i_clk_sys or negedge rstn) begin
		if (!rstn) begin
			fail_q <= 1'b0;
		end else begin
			fail_q <= fail_d;
		end
	end

	// ******************************
	// read paths
	// ******************************
	wire logic [7:0] status_word = 8'(fail_q) << POS_ALLOC_FAIL;

	// host read selects, one per mapped offset
	wire logic hs_tgt = (i_host_addr == ADDR_ALLOC_TARGET);
	wire logic hs_asg = (i_host_addr == ADDR_ASSIGNED);
	wire logic hs_spd = (i_host_addr == ADDR_LINK_SPEED);
	wire logic hs_ot = (i_host_addr == ADDR_OT_THRESH);
	wire logic hs_tmr = (i_host_addr == ADDR_BAL_TIMER);
	wire logic hs_sts = (i_host_addr == ADDR_LINK_STATUS);
	// chain selects leave the speed offset out
	wire logic cs_tgt = (i_chain_addr == ADDR_ALLOC_TARGET);
	wire logic cs_asg = (i_chain_addr == ADDR_ASSIGNED);
	wire logic cs_ot = (i_chain_addr == ADDR_OT_THRESH);
	wire logic cs_tmr = (i_chain_addr == ADDR_BAL_TIMER);
	wire logic cs_sts = (i_chain_addr == ADDR_LINK_STATUS);

	// and-or muxes, unselected offsets read zero
	wire logic [7:0] host_mux = ({8{hs_tgt}} & target_q) |
		({8{hs_asg}} & assigned_q) |
		({8{hs_spd}} & speed_q) |
		({8{hs_ot}} & ot_q) |
		({8{hs_tmr}} & timer_q) |
		({8{hs_sts}} & status_word);
	wire logic [7:0] chain_mux = ({8{cs_tgt}} & target_q) |
		({8{cs_asg}} & assigned_q) |
		({8{cs_ot}} & ot_q) |
		({8{cs_tmr}} & timer_q) |
		({8{cs_sts}} & status_word);
	// hit flags follow the same selects
	wire logic host_map = hs_tgt | hs_asg | hs_spd | hs_ot | hs_tmr | hs_sts;
	wire logic chain_map = cs_tgt | cs_asg | cs_ot | cs_tmr | cs_sts;

	logic [7:0] host_rdata_q;
	logic [7:0] chain_rdata_q;

	// read data registered one cycle after the read strobe
	always_ff @(posedge i_clk_sys or negedge rstn) begin
		if (!rstn) begin
			host_rdata_q <= RESET_VALUE;
			chain_rdata_q <= RESET_VALUE;
		end else begin
			if (i_host_rd) begin
				host_rdata_q <= host_mux;
			end
			if (i_chain_rd) begin
				chain_rdata_q <= chain_mux;
			end
		end
	end

	assign o_host_rdata = host_rdata_q;
	assign o_chain_rdata = chain_rdata_q;
	assign o_host_hit = host_map;
	assign o_chain_hit = chain_map;
	assign o_target_addr = target_q[5:0];
	assign o_device_addr = assigned_q[5:0];
	assign o_alloc_fail = fail_q;
	assign o_ot_warn_code = ot_q[POS_OT_WARN +: 4];
	assign o_ot_shut_code = ot_q[POS_OT_SHUT +: 4];

	// ******************************
	// field decode
	// ******************************
	cfg_field_decode u_decode (
		.i_timer(timer_q),
		.i_speed(speed_q),
		.i_ot(ot_q),
		.o_duty_pct(o_duty_pct),
		.o_slot_s(o_slot_s),
		.o_tclk_khz(o_tclk_khz),
		.o_settle_cycles(o_settle_cycles),
		.o_link_khz(o_link_khz),
		.o_speed_invalid(o_speed_invalid),
		.o_warn_mv(o_warn_mv),
		.o_shut_mv(o_shut_mv)
	);
endmodule
`default_nettype wire

// file: bench/chain_config_timer_regs_assertions.sv
// concurrent checks on the register group ports
`timescale 1ns/10ps
`default_nettype none
module chain_cfg_checker
	import chain_cfg_pkg::*;
(
	input wire logic i_clk_sys,
	input wire logic i_rstn,
	input wire logic i_host_wr,
	input wire logic i_host_rd,
	input wire logic [7:0] i_host_addr,
	input wire logic [7:0] i_host_wdata,
	input wire logic [7:0] o_host_rdata,
	input wire logic o_host_hit,
	input wire logic i_chain_wr,
	input wire logic [7:0] i_chain_addr,
	input wire logic o_chain_hit,
	input wire logic i_alloc_done,
	input wire logic [5:0] i_alloc_addr,
	input wire logic i_alloc_start_result,
	input wire logic i_alloc_start_fail,
	input wire logic [5:0] o_target_addr,
	input wire logic [5:0] o_device_addr,
	input wire logic o_alloc_fail,
	input wire logic [5:0] o_link_khz,
	input wire logic o_speed_invalid,
	input wire logic [3:0] o_ot_warn_code,
	input wire logic [12:0] o_warn_mv,
	input wire logic [4:0] o_settle_cycles
);
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_rstn);
	target_store_a: assert property (
		i_host_wr && !i_chain_wr && i_host_addr == 8'h1a |=>
		o_target_addr == $past(i_host_wdata[5:0]))
		else $error("target address not stored");
	alloc_load_a: assert property (
		i_alloc_done |=> o_device_addr == $past(i_alloc_addr))
		else $error("allocated address not loaded");
	assigned_ro_a: assert property (
		i_host_wr && i_host_addr == 8'h1b && !i_alloc_done |=>
		$stable(o_device_addr))
		else $error("allocated address changed by write");
	speed_flag_a: assert property (
		o_speed_invalid |-> o_link_khz == 6'h00)
		else $error("reserved speed shows a rate");
	chain_speed_a: assert property (
		i_chain_addr == 8'h1c |-> !o_chain_hit)
		else $error("speed register mapped on chain");
	chain_hit_map_a: assert property (
		o_chain_hit == (i_chain_addr >= 8'h19 &&
		i_chain_addr <= 8'h1e && i_chain_addr != 8'h1c))
		else $error("chain hit flag wrong");
	warn_mv_a: assert property (
		o_warn_mv == OT_BASE_MV + OT_STEP_MV * 13'(o_ot_warn_code))
		else $error("warning threshold wrong");
	settle_len_a: assert property (
		i_host_rd && i_host_addr == 8'h1e |=>
		o_settle_cycles == (o_host_rdata[7] ? 5'h0f : 5'h05))
		else $error("settle length wrong");
	start_fail_a: assert property (
		i_alloc_start_result |=> o_alloc_fail == $past(i_alloc_start_fail))
		else $error("start status not stored");
	unmapped_zero_a: assert property (
		i_host_rd && !o_host_hit |=> o_host_rdata == 8'h00)
		else $error("unmapped read not zero");
	host_hit_map_a: assert property (
		o_host_hit == (i_host_addr >= 8'h19 && i_host_addr <= 8'h1e))
		else $error("host hit flag wrong");
endmodule
`default_nettype wire

// file: bench/host_port_model.sv
// host side bus model issuing one-cycle strobes
`timescale 1ns/10ps
`default_nettype none
module host_port_model (
	input wire logic i_clk,
	input wire logic [7:0] i_rdata,
	output logic o_wr,
	output logic o_rd,
	output logic [7:0] o_addr,
	output logic [7:0] o_wdata
);
	// idle bus
	initial begin
		o_wr = 1'b0;
		o_rd = 1'b0;
		o_addr = 8'h00;
		o_wdata = 8'h00;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		if (a == 8'h1a && d[5:0] == 6'h00) return;
		@(negedge i_clk);
		o_addr = a;
		o_wdata = d;
		o_wr = 1'b1;
		@(negedge i_clk);
		o_wr = 1'b0;
		o_addr = ~a; // released lines move
		o_wdata = ~d;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge i_clk);
		o_addr = a;
		o_rd = 1'b1;
		@(negedge i_clk);
		o_rd = 1'b0;
		o_addr = ~a;
		d = i_rdata;
	endtask
endmodule
`default_nettype wire

// file: bench/test_chain_config_timer_regs.sv
// self-checking bench for the chain configuration register group
`timescale 1ns/10ps
`default_nettype none
module test_chain_config_timer_regs
	import chain_cfg_pkg::*;
;
	logic i_clk_sys = 1'b0;
	logic i_rstn = 1'b0;
	logic hw, hr, cw, cr, i_alloc_done, res, fail;
	logic [7:0] ha, hd, hq, ca, cd, cq, v;
	logic [5:0] aa, o_target_addr, o_device_addr;
	logic [5:0] o_link_khz, o_duty_pct, o_slot_s;
	logic o_host_hit, o_chain_hit, o_alloc_fail, o_speed_invalid;
	logic [3:0] o_ot_warn_code, o_ot_shut_code;
	logic [12:0] o_warn_mv, o_shut_mv;
	logic [7:0] o_tclk_khz;
	logic [4:0] o_settle_cycles;
	int failures = 0;
	int num_checks = 0;
	// expected decodes, from the rule tables
	logic [5:0] duty_t [8] = '{6'h19, 6'h0f, 6'h14, 6'h1e,
		6'h23, 6'h28, 6'h2d, 6'h32};
	logic [5:0] slot_t [4] = '{6'h01, 6'h08, 6'h10, 6'h20};
	logic [7:0] tclk_t [4] = '{8'h64, 8'h19, 8'h32, 8'hc8};
	logic [5:0] link_t [4] = '{6'h05, 6'h14, 6'h28, 6'h00};
	always #25 i_clk_sys = ~i_clk_sys;
	host_port_model hm (
		.i_clk(i_clk_sys),
		.i_rdata(hq),
		.o_wr(hw),
		.o_rd(hr),
		.o_addr(ha),
		.o_wdata(hd)
	);
	host_port_model cm (
		.i_clk(i_clk_sys),
		.i_rdata(cq),
		.o_wr(cw),
		.o_rd(cr),
		.o_addr(ca),
		.o_wdata(cd)
	);
	chain_config_timer_regs dut (
		.i_clk_sys(i_clk_sys),
		.i_rstn(i_rstn),
		.i_host_wr(hw),
		.i_host_rd(hr),
		.i_host_addr(ha),
		.i_host_wdata(hd),
		.o_host_rdata(hq),
		.o_host_hit(o_host_hit),
		.i_chain_wr(cw),
		.i_chain_rd(cr),
		.i_chain_addr(ca),
		.i_chain_wdata(cd),
		.o_chain_rdata(cq),
		.o_chain_hit(o_chain_hit),
		.i_alloc_done(i_alloc_done),
		.i_alloc_addr(aa),
		.i_alloc_start_result(res),
		.i_alloc_start_fail(fail),
		.o_target_addr(o_target_addr),
		.o_device_addr(o_device_addr),
		.o_alloc_fail(o_alloc_fail),
		.o_link_khz(o_link_khz),
		.o_speed_invalid(o_speed_invalid),
		.o_ot_warn_code(o_ot_warn_code),
		.o_ot_shut_code(o_ot_shut_code),
		.o_warn_mv(o_warn_mv),
		.o_shut_mv(o_shut_mv),
		.o_duty_pct(o_duty_pct),
		.o_slot_s(o_slot_s),
		.o_tclk_khz(o_tclk_khz),
		.o_settle_cycles(o_settle_cycles)
	);
	task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e) begin
			failures++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic hchk(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		hm.rd(a, d);
		check("host read", 32'(d), 32'(e));
	endtask
	task automatic cchk(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		cm.rd(a, d);
		check("chain read", 32'(d), 32'(e));
	endtask
	task automatic pulse(input logic dn, input logic [5:0] ad, input logic rs, input logic f);
		@(negedge i_clk_sys);
		{i_alloc_done, aa, res, fail} = {dn, ad, rs, f};
		@(negedge i_clk_sys);
		{i_alloc_done, res} = 2'h0;
	endtask
	task automatic give_verdict();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// watchdog
	initial begin
		repeat (3000) @(posedge i_clk_sys);
		failures++;
		give_verdict();
	end
	// main sequence
	initial begin
		{i_alloc_done, aa, res, fail} = 9'h000;
		repeat (4) @(posedge i_clk_sys);
		@(negedge i_clk_sys);
		i_rstn = 1'b1;
		repeat (3) @(posedge i_clk_sys);
		for (int a = 8'h19; a <= 8'h1e; a++) hchk(8'(a), 8'h00);
		check("reset duty", 32'(o_duty_pct), 32'h19);
		check("reset slot", 32'(o_slot_s), 32'h01);
		check("reset tclk", 32'(o_tclk_khz), 32'h64);
		check("reset settle", 32'(o_settle_cycles), 32'h05);
		check("reset link", 32'(o_link_khz), 32'h05);
		check("reset warn", 32'(o_warn_mv), 32'hc5d);
		hm.wr(ADDR_ALLOC_TARGET, 8'hff);
		cchk(ADDR_ALLOC_TARGET, 8'h3f);
		cm.wr(ADDR_ALLOC_TARGET, 8'h05);
		hchk(ADDR_ALLOC_TARGET, 8'h05);
		check("target pin", 32'(o_target_addr), 32'h05);
		// both ports write the target at one edge, host wins
		fork
			hm.wr(ADDR_ALLOC_TARGET, 8'h11);
			cm.wr(ADDR_ALLOC_TARGET, 8'h22);
		join
		cchk(ADDR_ALLOC_TARGET, 8'h11);
		hm.wr(ADDR_ASSIGNED, 8'hff);
		pulse(1'b1, 6'h2a, 1'b0, 1'b0);
		hm.wr(ADDR_ASSIGNED, 8'h00);
		cm.wr(ADDR_ASSIGNED, 8'h00);
		cchk(ADDR_ASSIGNED, 8'h2a);
		check("device pin", 32'(o_device_addr), 32'h2a);
		for (int j = 0; j < 4; j++) begin
			hm.wr(ADDR_LINK_SPEED, {6'h3f, 2'(j)});
			hchk(ADDR_LINK_SPEED, {6'h00, 2'(j)});
			check("link rate", 32'(o_link_khz), 32'(link_t[j]));
			check("link flag", 32'(o_speed_invalid), 32'(j == 3));
		end
		cm.wr(ADDR_LINK_SPEED, 8'h00);
		cchk(ADDR_LINK_SPEED, 8'h00);
		hchk(ADDR_LINK_SPEED, 8'h03);
		hm.wr(ADDR_OT_THRESH, 8'hf0);
		check("ot codes", 32'({o_ot_shut_code, o_ot_warn_code}), 32'hf0);
		check("ot warn low", 32'(o_warn_mv), 32'h0c5d);
		check("ot shut high", 32'(o_shut_mv), 32'h103b);
		cm.wr(ADDR_OT_THRESH, 8'h5a);
		check("ot warn mid", 32'(o_warn_mv), 32'h0ef1);
		check("ot shut mid", 32'(o_shut_mv), 32'h0da7);
		for (int i = 0; i < 8; i++) begin
			v = {i[0], i[1:0], i[1:0], i[2:0]};
			if (i[0]) cm.wr(ADDR_BAL_TIMER, v);
			else hm.wr(ADDR_BAL_TIMER, v);
			hchk(ADDR_BAL_TIMER, v);
			check("duty", 32'(o_duty_pct), 32'(duty_t[i]));
			check("slot", 32'(o_slot_s), 32'(slot_t[i%4]));
			check("tclk", 32'(o_tclk_khz), 32'(tclk_t[i%4]));
			check("settle", 32'(o_settle_cycles), i[0] ? 32'h0f : 32'h05);
		end
		pulse(1'b0, 6'h00, 1'b1, 1'b1);
		hm.wr(ADDR_LINK_STATUS, 8'h00);
		cchk(ADDR_LINK_STATUS, 8'h04);
		check("fail pin", 32'(o_alloc_fail), 32'h1);
		pulse(1'b0, 6'h00, 1'b1, 1'b0);
		hchk(ADDR_LINK_STATUS, 8'h00);
		check("fail pin", 32'(o_alloc_fail), 32'h0);
		hm.wr(8'h30, 8'hff);
		hchk(8'h30, 8'h00);
		give_verdict();
	end
endmodule
bind chain_config_timer_regs chain_cfg_checker u_chk (.*);
`default_nettype wire
